// [hdl/bbp_pkg.sv]
// constants, types and tables shared by the boolean bit processor
// What this block does
// - set, clear, invert of carry alone: one opcode byte, one cycle
// - addressed set, clear, invert: opcode plus bit address byte, one cycle
// - copy addressed bit into carry: two bytes, one cycle
// - copy carry into addressed bit: two bytes, two cycles
// - carry becomes carry AND addressed bit: two bytes, two cycles
// - carry becomes carry OR addressed bit: two bytes, two cycles
// - inverted-operand AND/OR variants leave addressed bit unchanged: two bytes, two cycles
// - branch on carry / no carry: opcode plus displacement, two cycles always
// - branch on bit set / clear: three bytes, two cycles
// - branch on bit set then clear it in same instruction: three bytes, two cycles
// - signed 8-bit displacement added to address of next instruction
// - carry is the one-bit accumulator; 128 general flag bits exist
// - all 32 port pins individually addressable as input, output or both
// - 51 further bits control and report cpu, timer, serial, interrupt
// - only defined bit addresses need exist; others read zero
// - bit addresses 0..127 map onto flag bytes 20H..2FH, lsb first
// - addresses 80H..0FFH: upper five bits pick register, lower three bit
package bbp_pkg;

   // *****************************************
   // opcode byte encoding
   // *****************************************
   localparam logic [7:0] OPC_SET_C = 8'h01;
   localparam logic [7:0] OPC_CLR_C = 8'h02;
   localparam logic [7:0] OPC_INV_C = 8'h03;
   localparam logic [7:0] OPC_SET_BIT = 8'h11;
   localparam logic [7:0] OPC_CLR_BIT = 8'h12;
   localparam logic [7:0] OPC_INV_BIT = 8'h13;
   localparam logic [7:0] OPC_BIT_TO_C = 8'h14;
   localparam logic [7:0] OPC_C_TO_BIT = 8'h15;
   localparam logic [7:0] OPC_AND_C = 8'h16;
   localparam logic [7:0] OPC_ANDN_C = 8'h17;
   localparam logic [7:0] OPC_OR_C = 8'h18;
   localparam logic [7:0] OPC_ORN_C = 8'h19;
   localparam logic [7:0] OPC_BR_C = 8'h21;
   localparam logic [7:0] OPC_BR_NC = 8'h22;
   localparam logic [7:0] OPC_BR_SET = 8'h31;
   localparam logic [7:0] OPC_BR_CLR = 8'h32;
   localparam logic [7:0] OPC_BR_SET_CLR = 8'h33;

   // *****************************************
   // lengths, cycle counts, storage layout
   // *****************************************
   localparam logic [1:0] LEN_1 = 2'd1;
   localparam logic [1:0] LEN_2 = 2'd2;
   localparam logic [1:0] LEN_3 = 2'd3;
   localparam logic [1:0] CYC_1 = 2'd1;
   localparam logic [1:0] CYC_2 = 2'd2;
   localparam int NUM_SLOTS = 32;
   localparam int NUM_PORTS = 4;
   localparam logic [4:0] SLOT_PSW = 5'd26;
   localparam logic [2:0] POS_CARRY = 3'd7;
   localparam logic [4:0] SLOT_TCON = 5'd17;
   localparam logic [4:0] SLOT_SCON = 5'd19;
   localparam logic [4:0] SLOT_IE = 5'd21;
   localparam logic [4:0] SLOT_IP = 5'd23;
   localparam logic [4:0] SLOT_ACC = 5'd28;
   localparam logic [4:0] SLOT_B = 5'd30;

   // slot 0..15 flag bytes, 16..31 special registers 80H..F8H in steps of 8
   localparam logic [NUM_SLOTS-1:0][7:0] SLOT_MASK = {
      8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00,
      8'h1F, 8'hFF, 8'h9F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      {16{8'hFF}}};
   localparam logic [NUM_SLOTS-1:0][7:0] SLOT_RESET = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF,
      {16{8'h00}}};

   // *****************************************
   // types
   // *****************************************
   typedef enum logic [3:0] {
      K_NOP, K_SET, K_CLR, K_INV, K_BIT_TO_C, K_C_TO_BIT, K_AND, K_ANDN, K_OR, K_ORN,
      K_BR_C, K_BR_NC, K_BR_SET, K_BR_CLR, K_BR_SET_CLR
   } bbp_kind_t;

   typedef struct packed {
      bbp_kind_t kind;
      logic on_carry;
      logic illegal;
      logic [1:0] len;
      logic [1:0] cycles;
   } bbp_dec_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] bit_addr;
      logic [7:0] disp;
      logic [15:0] next_pc;
   } bbp_instr_t;

   typedef struct packed {
      logic taken;
      logic illegal;
      logic [1:0] len;
      logic [15:0] target;
   } bbp_result_t;

   typedef struct packed {
      logic [7:0] tcon;
      logic [7:0] scon;
   } bbp_status_t;

   typedef struct packed {
      logic [7:0] psw;
      logic [7:0] acc;
      logic [7:0] b;
      logic [7:0] tcon;
      logic [7:0] scon;
      logic [7:0] ie;
      logic [7:0] ip;
   } bbp_ctrl_t;

endpackage : bbp_pkg

// [hdl/bbp_top.sv]
// boolean bit processor: decode, bit storage, carry logic and branch target
module bbp_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // instruction issue
   input wire logic i_issue,
   input wire bbp_pkg::bbp_instr_t i_instr,
   output logic o_ready,
   // instruction completion
   output logic o_done,
   output bbp_pkg::bbp_result_t o_result,
   // hardware status set pulses, same clock
   input wire bbp_pkg::bbp_status_t i_status_set,
   // register bits seen by the rest of the core
   output bbp_pkg::bbp_ctrl_t o_ctrl,
   output logic o_carry,
   // port pins, open drain with pull-up outside
   input wire logic [31:0] i_pin,
   output logic [31:0] o_pin,
   output logic [31:0] o_pin_oe
);

   // *****************************************
   // decode
   // *****************************************
   function automatic bbp_pkg::bbp_dec_t decode(input logic [7:0] opc);
      bbp_pkg::bbp_dec_t d;
      d = '{kind: bbp_pkg::K_NOP, on_carry: 1'b0, illegal: 1'b0, len: bbp_pkg::LEN_1,
            cycles: bbp_pkg::CYC_1};
      case (opc)
         bbp_pkg::OPC_SET_C: begin
            d.kind = bbp_pkg::K_SET;
            d.on_carry = 1'b1;
         end
         bbp_pkg::OPC_CLR_C: begin
            d.kind = bbp_pkg::K_CLR;
            d.on_carry = 1'b1;
         end
         bbp_pkg::OPC_INV_C: begin
            d.kind = bbp_pkg::K_INV;
            d.on_carry = 1'b1;
         end
         bbp_pkg::OPC_SET_BIT: begin
            d.kind = bbp_pkg::K_SET;
            d.len = bbp_pkg::LEN_2;
         end
         bbp_pkg::OPC_CLR_BIT: begin
            d.kind = bbp_pkg::K_CLR;
            d.len = bbp_pkg::LEN_2;
         end
         bbp_pkg::OPC_INV_BIT: begin
            d.kind = bbp_pkg::K_INV;
            d.len = bbp_pkg::LEN_2;
         end
         bbp_pkg::OPC_BIT_TO_C: begin
            d.kind = bbp_pkg::K_BIT_TO_C;
            d.len = bbp_pkg::LEN_2;
         end
         bbp_pkg::OPC_C_TO_BIT: begin
            d.kind = bbp_pkg::K_C_TO_BIT;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_AND_C: begin
            d.kind = bbp_pkg::K_AND;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_OR_C: begin
            d.kind = bbp_pkg::K_OR;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_ANDN_C: begin
            d.kind = bbp_pkg::K_ANDN;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_ORN_C: begin
            d.kind = bbp_pkg::K_ORN;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_BR_C: begin
            d.kind = bbp_pkg::K_BR_C;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_BR_NC: begin
            d.kind = bbp_pkg::K_BR_NC;
            d.len = bbp_pkg::LEN_2;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_BR_SET: begin
            d.kind = bbp_pkg::K_BR_SET;
            d.len = bbp_pkg::LEN_3;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_BR_CLR: begin
            d.kind = bbp_pkg::K_BR_CLR;
            d.len = bbp_pkg::LEN_3;
            d.cycles = bbp_pkg::CYC_2;
         end
         bbp_pkg::OPC_BR_SET_CLR: begin
            d.kind = bbp_pkg::K_BR_SET_CLR;
            d.len = bbp_pkg::LEN_3;
            d.cycles = bbp_pkg::CYC_2;
         end
         default: begin
            d.illegal = 1'b1;
         end
      endcase
      return d;
   endfunction

   // bit address to storage slot: low half flag bytes, high half registers
   function automatic logic [4:0] slot_of(input logic [7:0] addr);
      return {addr[7], addr[6:3]};
   endfunction

   // ports sit at the even register slots 80H, 90H, A0H, B0H
   function automatic logic is_port(input logic [4:0] slot);
      return slot[4] && !slot[3] && !slot[0];
   endfunction

   // *****************************************
   // pin synchronisers
   // *****************************************
   logic [31:0] pin_s1_r;
   logic [31:0] pin_s2_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_r <= 32'hFFFF_FFFF;
         pin_s2_r <= 32'hFFFF_FFFF;
      end else begin
         pin_s1_r <= i_pin;
         pin_s2_r <= pin_s1_r;
      end
   end

   // *****************************************
   // sequencing and storage
   // *****************************************
   typedef enum logic {ST_IDLE, ST_EXEC2} bbp_state_t;

   bbp_state_t state_r, state_nxt;
   bbp_pkg::bbp_instr_t held_r, held_nxt;
   logic [bbp_pkg::NUM_SLOTS-1:0][7:0] mem_r, mem_nxt;
   logic done_r, done_nxt;
   bbp_pkg::bbp_result_t res_r, res_nxt;

   bbp_pkg::bbp_instr_t cur;
   bbp_pkg::bbp_dec_t dec;
   logic exec;
   logic [4:0] slot;
   logic [2:0] pos;
   logic [7:0] pin_byte;
   logic [7:0] op_latch;
   logic op_test;
   logic carry;
   logic bit_wr;
   logic bit_val;
   logic new_carry;
   logic br;
   logic [15:0] disp_ext;

   // one instruction at a time: a two-cycle op blocks the issue port for one edge
   assign o_ready = (state_r == ST_IDLE);

   always_comb begin
      cur = (state_r == ST_EXEC2) ? held_r : i_instr;
      dec = decode(cur.opcode);
      slot = slot_of(cur.bit_addr);
      pos = cur.bit_addr[2:0];
      pin_byte = pin_s2_r[8 * slot[2:1] +: 8];
      // tests of a port look at the pin, except the set-clear branch; writes modify the latch
      op_latch = mem_r[slot] & bbp_pkg::SLOT_MASK[slot];
      op_test = is_port(slot) ? pin_byte[pos] : op_latch[pos];
      carry = mem_r[bbp_pkg::SLOT_PSW][bbp_pkg::POS_CARRY];
      exec = (state_r == ST_EXEC2) || (i_issue && dec.cycles == bbp_pkg::CYC_1);
      disp_ext = {{8{cur.disp[7]}}, cur.disp};
      state_nxt = state_r;
      held_nxt = held_r;
      mem_nxt = mem_r;
      done_nxt = 1'b0;
      res_nxt = res_r;
      bit_wr = 1'b0;
      bit_val = 1'b0;
      new_carry = carry;
      br = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (i_issue && dec.cycles == bbp_pkg::CYC_2) begin
               held_nxt = i_instr;
               state_nxt = ST_EXEC2;
            end
         end
         ST_EXEC2: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (exec) begin
         case (dec.kind)
            bbp_pkg::K_SET: begin
               if (dec.on_carry) new_carry = 1'b1;
               else begin
                  bit_wr = 1'b1;
                  bit_val = 1'b1;
               end
            end
            bbp_pkg::K_CLR: begin
               if (dec.on_carry) new_carry = 1'b0;
               else begin
                  bit_wr = 1'b1;
                  bit_val = 1'b0;
               end
            end
            bbp_pkg::K_INV: begin
               if (dec.on_carry) new_carry = !carry;
               else begin
                  bit_wr = 1'b1;
                  bit_val = !op_latch[pos];
               end
            end
            bbp_pkg::K_BIT_TO_C: new_carry = op_test;
            bbp_pkg::K_C_TO_BIT: begin
               bit_wr = 1'b1;
               bit_val = carry;
            end
            bbp_pkg::K_AND: new_carry = carry & op_test;
            bbp_pkg::K_OR: new_carry = carry | op_test;
            bbp_pkg::K_ANDN: new_carry = carry & !op_test;
            bbp_pkg::K_ORN: new_carry = carry | !op_test;
            bbp_pkg::K_BR_C: br = carry;
            bbp_pkg::K_BR_NC: br = !carry;
            bbp_pkg::K_BR_SET: br = op_test;
            bbp_pkg::K_BR_CLR: br = !op_test;
            bbp_pkg::K_BR_SET_CLR: begin
               // decide on the latch, as the same byte is rewritten
               br = op_latch[pos];
               bit_wr = op_latch[pos];
               bit_val = 1'b0;
            end
            default: br = 1'b0;
         endcase
         // only the selected bit of the byte changes
         if (bit_wr) mem_nxt[slot][pos] = bit_val;
         mem_nxt[bbp_pkg::SLOT_PSW][bbp_pkg::POS_CARRY] =
            (bit_wr && slot == bbp_pkg::SLOT_PSW && pos == bbp_pkg::POS_CARRY) ? bit_val : new_carry;
         done_nxt = 1'b1;
         res_nxt.taken = br;
         res_nxt.illegal = dec.illegal;
         res_nxt.len = dec.len;
         res_nxt.target = cur.next_pc + disp_ext;
      end
      // peripheral sets land after the instruction write: set wins
      mem_nxt[bbp_pkg::SLOT_TCON] = mem_nxt[bbp_pkg::SLOT_TCON] | i_status_set.tcon;
      mem_nxt[bbp_pkg::SLOT_SCON] = mem_nxt[bbp_pkg::SLOT_SCON] | i_status_set.scon;
      // unimplemented positions never hold a one
      for (int s = 0; s < bbp_pkg::NUM_SLOTS; s++) begin
         mem_nxt[s] = mem_nxt[s] & bbp_pkg::SLOT_MASK[s];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         held_r <= '0;
         mem_r <= bbp_pkg::SLOT_RESET;
         done_r <= 1'b0;
         res_r <= '0;
      end else begin
         state_r <= state_nxt;
         held_r <= held_nxt;
         mem_r <= mem_nxt;
         done_r <= done_nxt;
         res_r <= res_nxt;
      end
   end

   // *****************************************
   // outputs
   // *****************************************
   assign o_done = done_r;
   assign o_result = res_r;
   assign o_carry = mem_r[bbp_pkg::SLOT_PSW][bbp_pkg::POS_CARRY];
   assign o_ctrl.psw = mem_r[bbp_pkg::SLOT_PSW];
   assign o_ctrl.acc = mem_r[bbp_pkg::SLOT_ACC];
   assign o_ctrl.b = mem_r[bbp_pkg::SLOT_B];
   assign o_ctrl.tcon = mem_r[bbp_pkg::SLOT_TCON];
   assign o_ctrl.scon = mem_r[bbp_pkg::SLOT_SCON];
   assign o_ctrl.ie = mem_r[bbp_pkg::SLOT_IE];
   assign o_ctrl.ip = mem_r[bbp_pkg::SLOT_IP];

   // open drain: a latch zero pulls the pin low, a one releases it
   for (genvar p = 0; p < bbp_pkg::NUM_PORTS; p++) begin : g_port
      assign o_pin[8*p +: 8] = 8'h00;
      assign o_pin_oe[8*p +: 8] = ~mem_r[16 + 2*p];
   end

endmodule // bbp_top

// [sim/bbp_props.sv]
// port checker for the boolean bit processor, with its bind
module bbp_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // instruction port
   input wire logic i_issue,
   input wire bbp_pkg::bbp_instr_t i_instr,
   input wire logic o_ready,
   input wire logic o_done,
   input wire bbp_pkg::bbp_result_t o_result,
   // state seen outside
   input wire bbp_pkg::bbp_ctrl_t o_ctrl,
   input wire logic o_carry,
   input wire logic [31:0] o_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic take;
   logic [7:0] op_r, op_nxt;
   logic [15:0] tgt_r, tgt_nxt;
   assign take = i_issue && o_ready;
   // remember what was taken so results can be judged at completion
   always_comb begin
      op_nxt = take ? i_instr.opcode : op_r;
      tgt_nxt = take ? i_instr.next_pc + {{8{i_instr.disp[7]}}, i_instr.disp} : tgt_r;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         op_r <= 8'h00;
         tgt_r <= 16'h0000;
      end else begin
         op_r <= op_nxt;
         tgt_r <= tgt_nxt;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_carry_set: assert property (
      take && i_instr.opcode == 8'h01 |=> o_done && o_carry && o_result.len == 2'd1)
      else $error("carry set wrong");
   chk_carry_inv: assert property (take && i_instr.opcode == 8'h03 |=> o_carry != $past(o_carry))
      else $error("carry invert wrong");
   chk_one_cycle: assert property (
      take && i_instr.opcode inside {[8'h11:8'h14]} |=> o_done && o_result.len == 2'd2)
      else $error("one cycle bit op wrong");
   chk_two_cycle: assert property (
      take && i_instr.opcode inside {[8'h15:8'h19], 8'h21, 8'h22}
      |=> !o_ready && !o_done ##1 o_done && o_result.len == 2'd2)
      else $error("two cycle op wrong");
   chk_three_byte: assert property (
      take && i_instr.opcode inside {[8'h31:8'h33]} |=> !o_done ##1 o_done && o_result.len == 2'd3)
      else $error("bit branch wrong");
   chk_target_sum: assert property (o_done && op_r[7:4] >= 4'h2 |-> o_result.target == tgt_r)
      else $error("branch target wrong");
   chk_carry_branch: assert property (
      take && i_instr.opcode == 8'h21 |=> ##1 o_result.taken == $past(o_carry, 2))
      else $error("carry branch decision wrong");
   chk_acc_bit_set: assert property (
      take && i_instr.opcode == 8'h11 && i_instr.bit_addr[7:3] == 5'h1C
      |=> o_ctrl.acc == ($past(o_ctrl.acc) | (8'h01 << $past(i_instr.bit_addr[2:0]))))
      else $error("addressed bit write disturbed its byte");
   chk_pin_drive: assert property (o_pin == 32'h0000_0000)
      else $error("pin drive value not low");
   cover property (take && i_instr.opcode == 8'h33);
   cover property (o_done && o_result.taken);
   cover property (o_done && o_result.illegal);
endmodule // bbp_props

bind bbp_top bbp_props u_props (.i_clk, .i_rst, .i_issue, .i_instr, .o_ready, .o_done, .o_result, .o_ctrl,
   .o_carry, .o_pin);

// [sim/bbp_tb_top.sv]
// self-checking bench for the boolean bit processor
module bbp_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst, i_issue, o_ready, o_done, o_carry;
   bbp_pkg::bbp_instr_t i_instr;
   bbp_pkg::bbp_result_t o_result;
   bbp_pkg::bbp_status_t i_status_set;
   bbp_pkg::bbp_ctrl_t o_ctrl;
   logic [31:0] i_pin, o_pin, o_pin_oe;
   int fails, compares, cyc;
   logic [7:0] lop [8] = '{8'h01, 8'h16, 8'h17, 8'h19, 8'h16, 8'h18, 8'h14, 8'h15};
   logic [7:0] lad [8] = '{8'h00, 8'hE0, 8'hE0, 8'hE1, 8'hE1, 8'hE0, 8'hE1, 8'hE0};
   logic lc [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   int lcy [8] = '{1, 2, 2, 2, 2, 2, 1, 2};

   bbp_top u_dut (.i_clk, .i_rst, .i_issue, .i_instr, .o_ready, .o_done, .o_result, .i_status_set, .o_ctrl,
      .o_carry, .i_pin, .o_pin, .o_pin_oe);

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one instruction, next_pc fixed so targets are easy to predict
   task automatic run(input logic [7:0] op, input logic [7:0] ba, input logic [7:0] dp);
      @(posedge i_clk);
      i_issue <= 1'b1;
      i_instr <= '{op, ba, dp, 16'h1000};
      @(posedge i_clk);
      i_issue <= 1'b0;
      cyc = 1;
      #1;
      while (o_done !== 1'b1) begin
         if (cyc > 4) begin
            fails++;
            give_verdict();
         end
         @(posedge i_clk);
         #1;
         cyc++;
      end
   endtask

   task automatic t_carry();
      run(bbp_pkg::OPC_SET_C, 8'h00, 8'h00);
      check("set c", {o_carry, cyc[1:0], o_result.len}, {1'b1, 2'd1, 2'd1});
      run(bbp_pkg::OPC_INV_C, 8'h00, 8'h00);
      check("inv c", {o_carry, cyc[1:0]}, {1'b0, 2'd1});
      run(bbp_pkg::OPC_INV_C, 8'h00, 8'h00);
      run(bbp_pkg::OPC_CLR_C, 8'h00, 8'h00);
      check("clr c", {o_carry, cyc[1:0]}, {1'b0, 2'd1});
      $display("carry test done");
   endtask

   task automatic t_bits();
      run(bbp_pkg::OPC_SET_BIT, 8'hE3, 8'h00);
      check("set bit", {o_ctrl.acc, cyc[1:0], o_result.len}, {8'h08, 2'd1, 2'd2});
      run(bbp_pkg::OPC_SET_BIT, 8'hE5, 8'h00);
      check("set keeps byte", o_ctrl.acc, 8'h28);
      run(bbp_pkg::OPC_INV_BIT, 8'hE3, 8'h00);
      run(bbp_pkg::OPC_CLR_BIT, 8'hE5, 8'h00);
      check("inv clr bit", o_ctrl.acc, 8'h00);
      run(bbp_pkg::OPC_SET_BIT, 8'hF7, 8'h00);
      run(bbp_pkg::OPC_SET_BIT, 8'hC0, 8'h00);
      check("b flag and hole", o_ctrl, 56'h0000_8000_0000_00);
      run(bbp_pkg::OPC_SET_C, 8'h00, 8'h00);
      run(bbp_pkg::OPC_BIT_TO_C, 8'hC0, 8'h00);
      check("hole reads zero", o_carry, 1'b0);
      run(bbp_pkg::OPC_SET_BIT, 8'h7F, 8'h00);
      run(bbp_pkg::OPC_BIT_TO_C, 8'h7F, 8'h00);
      check("flag top", o_carry, 1'b1);
      run(bbp_pkg::OPC_BIT_TO_C, 8'h7E, 8'h00);
      check("flag neighbour", o_carry, 1'b0);
      run(bbp_pkg::OPC_SET_BIT, 8'hD7, 8'h00);
      check("carry by address", {o_carry, o_ctrl.psw[7]}, 2'b11);
      $display("bit test done");
   endtask

   task automatic t_logic();
      run(bbp_pkg::OPC_SET_BIT, 8'hE0, 8'h00);
      for (int k = 0; k < 8; k++) begin
         run(lop[k], lad[k], 8'h00);
         check("logic step", {o_carry, cyc[1:0]}, {lc[k], 2'(lcy[k])});
      end
      check("copy into bit", o_ctrl.acc, 8'h00);
      $display("logic test done");
   endtask

   task automatic t_branch();
      run(bbp_pkg::OPC_BR_C, 8'h00, 8'h80);
      check("br c", {o_result.taken, o_result.target, cyc[1:0]}, {1'b0, 16'h0F80, 2'd2});
      run(bbp_pkg::OPC_BR_NC, 8'h00, 8'h7F);
      check("br nc", {o_result.taken, o_result.target, cyc[1:0]}, {1'b1, 16'h107F, 2'd2});
      run(bbp_pkg::OPC_SET_BIT, 8'hE2, 8'h00);
      run(bbp_pkg::OPC_BR_SET, 8'hE2, 8'h10);
      check("br set", {o_result.taken, o_result.len, cyc[1:0]}, {1'b1, 2'd3, 2'd2});
      run(bbp_pkg::OPC_BR_CLR, 8'hE2, 8'h10);
      check("br clr", o_result.taken, 1'b0);
      run(bbp_pkg::OPC_BR_SET_CLR, 8'hE2, 8'hF0);
      check("br set clr", {o_result.taken, o_ctrl.acc, o_result.target}, {1'b1, 8'h00, 16'h0FF0});
      run(bbp_pkg::OPC_BR_SET_CLR, 8'hE2, 8'hF0);
      check("br set clr again", o_result.taken, 1'b0);
      run(8'hFF, 8'h00, 8'h00);
      check("illegal", {o_result.illegal, o_result.len, cyc[1:0]}, {1'b1, 2'd1, 2'd1});
      $display("branch test done");
   endtask

   task automatic t_ports();
      run(bbp_pkg::OPC_CLR_BIT, 8'h80, 8'h00);
      check("pin drive", {o_pin_oe, o_pin}, {32'h0000_0001, 32'h0000_0000});
      run(bbp_pkg::OPC_SET_BIT, 8'h80, 8'h00);
      check("pin release", o_pin_oe, 32'h0000_0000);
      @(posedge i_clk);
      i_pin <= 32'hFFFF_FDFF;
      repeat (3) @(posedge i_clk);
      run(bbp_pkg::OPC_SET_C, 8'h00, 8'h00);
      run(bbp_pkg::OPC_BIT_TO_C, 8'h91, 8'h00);
      check("pin read", o_carry, 1'b0);
      @(posedge i_clk);
      i_pin <= 32'hFFFF_FFFF;
      i_status_set <= '{8'h80, 8'h01};
      @(posedge i_clk);
      i_status_set <= '0;
      #1;
      check("status set", {o_ctrl.tcon, o_ctrl.scon}, 16'h8001);
      run(bbp_pkg::OPC_SET_BIT, 8'hA8, 8'h00);
      check("control bit", o_ctrl.ie, 8'h01);
      $display("port test done");
   endtask

   initial begin
      i_rst = 1'b1;
      i_issue = 1'b0;
      i_instr = '0;
      i_status_set = '0;
      i_pin = 32'hFFFF_FFFF;
      repeat (3) @(posedge i_clk);
      check("reset state", {o_ready, o_done, o_carry, o_pin_oe}, {1'b1, 1'b0, 1'b0, 32'h0000_0000});
      check("reset regs", o_ctrl, 56'h0);
      check("reset result", o_result, 20'h0_0000);
      i_rst <= 1'b0;
      $display("reset test done");
      t_carry();
      t_bits();
      t_logic();
      t_branch();
      t_ports();
      give_verdict();
   end
endmodule // bbp_tb_top
